// ### verilog/amf_formatter.sv
// Purpose: serial output formatter of an eight-channel converter
// Assumes: host drives shift clock and frame sync; words arrive on clk
`timescale 1ns/100ps
`default_nettype none
module amf_formatter (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // conversion side
  input wire logic [amf_pkg::FBITS-1:0] conv_word,
  input wire logic conv_valid,
  input wire logic [amf_pkg::NCH-1:0] chan_ready,
  input wire logic [amf_pkg::NCH-1:0] mod_bits,
  // data outputs, bit 0 is first_data_output
  output logic [amf_pkg::NCH-1:0] data_out,
  // shift clock pin
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe_n,
  // ready_or_frame_pin
  input wire logic ready_or_frame_pin_in,
  output logic ready_or_frame_pin_out,
  output logic ready_or_frame_pin_oe_n,
  // chain input pin
  input wire logic chain_in,
  output logic chain_out,
  output logic chain_oe_n,
  // sync pin
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe_n,
  // clock_divider_select pin
  input wire logic clock_divider_select_in,
  output logic clock_divider_select_out,
  output logic clock_divider_select_oe_n
);
  import amf_pkg::*;

  typedef struct packed {
    logic [1:0] sclk_s;
    logic sclk_d;
    logic [1:0] fs_s;
    logic fs_d;
    logic [1:0] chain_s;
    logic [1:0] dsel_s;
    logic [1:0] sync_s;
    logic [CTRL_W-1:0] ctrl;
    logic [FBITS-1:0] hold;
    logic [7:0] hnb;
    logic hold_ok;
    logic [FBITS-1:0] sr;
    logic [7:0] cnt;
    logic [7:0] nbits;
    amf_phase_e ph;
    logic [5:0] divcnt;
    logic mclk;
    logic [NCH-1:0] dout;
    logic rof_out;
    logic rof_oe_n;
    logic sclk_out;
    logic sclk_oe_n;
    logic chain_out;
    logic chain_oe_n;
    logic sync_out;
    logic sync_oe_n;
    logic dsel_out;
    logic dsel_oe_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } amf_state_s;

  logic [1:0] rsync_r;
  logic rst_n;
  amf_state_s st_r, st_nxt;
  logic [NCH-1:0] pd;
  logic [1:0] md;
  logic [2:0] fmt;
  logic tmode, modmode, alloff, disc, fsp, dyn, run, fall, fs_rise, xfer;
  logic [FBITS-1:0] fixv, pk, src;
  logic [3:0] n;
  logic [7:0] new_nb, nb;
  logic [5:0] half;
  logic [31:0] status;

  // zeroes the bit each word shifts in, so words never bleed
  function automatic logic [FBITS-1:0] gshift(input logic [FBITS-1:0] v);
    logic [FBITS-1:0] r;
    r = v << 1;
    for (int i = 0; i < NCH; i++) begin
      r[i*WBITS] = 1'b0;
    end
    return r;
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsync_r <= 2'h0;
    end else begin
      rsync_r <= {rsync_r[0], 1'b1};
    end
  end
  assign rst_n = rsync_r[1];

  assign pd = st_r.ctrl[PD_LSB +: NCH];
  assign md = st_r.ctrl[MODE_LSB +: 2];
  assign fmt = st_r.ctrl[FMT_LSB +: 3];
  assign tmode = st_r.ctrl[TEST_LSB +: 2] == TEST_PINS;
  assign modmode = !tmode && fmt == FMT_MOD;
  assign alloff = &pd;
  assign disc = fmt == FMT_SPI_DISC || fmt == FMT_FS_DISC;
  assign fsp = fmt == FMT_FS_DYN || fmt == FMT_FS_FIX || fmt == FMT_FS_DISC;
  assign dyn = fmt == FMT_SPI_DYN || fmt == FMT_FS_DYN;
  assign run = !tmode && !modmode && !alloff;
  assign fall = st_r.sclk_d && !st_r.sclk_s[1];
  assign fs_rise = st_r.fs_s[1] && !st_r.fs_d;
  assign xfer = run && (fsp ? fs_rise && st_r.hold_ok : conv_valid);
  assign status = {12'h000, st_r.sync_s[1], st_r.hold_ok, st_r.ph,
                   st_r.nbits, st_r.cnt};

  // frame image: fixed slots, and packed slots of ready channels
  always_comb begin
    fixv = '0;
    pk = '0;
    n = 4'h0;
    for (int i = 0; i < NCH; i++) begin
      if (!pd[i]) begin
        fixv[FBITS-1-i*WBITS -: WBITS] = conv_word[i*WBITS +: WBITS];
      end
      if (!pd[i] && chan_ready[i]) begin
        pk = {pk[FBITS-WBITS-1:0], conv_word[i*WBITS +: WBITS]};
        n = n + 4'h1;
      end
    end
    pk = pk << (WBITS * (NCH - int'(n)));
    new_nb = dyn ? 8'(int'(n) * WBITS) : 8'(FBITS);
    src = fsp ? st_r.hold : (dyn ? pk : fixv);
    nb = fsp ? st_r.hnb : new_nb;
  end

  always_comb begin
    case (md)
      MODE_HS, MODE_HR: half = DIV_4 >> 1;
      MODE_LP: half = (st_r.dsel_s[1] ? DIV_8 : DIV_4) >> 1;
      MODE_LS: half = (st_r.dsel_s[1] ? DIV_40 : DIV_8) >> 1;
      default: half = DIV_4 >> 1;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_s = {st_r.sclk_s[0], sclk_in};
    st_nxt.sclk_d = st_r.sclk_s[1];
    st_nxt.fs_s = {st_r.fs_s[0], ready_or_frame_pin_in};
    st_nxt.fs_d = st_r.fs_s[1];
    st_nxt.chain_s = {st_r.chain_s[0], chain_in};
    st_nxt.dsel_s = {st_r.dsel_s[0], clock_divider_select_in};
    st_nxt.sync_s = {st_r.sync_s[0], sync_in};
    // apb: zero wait states, answer prepared during setup
    st_nxt.pready = psel && !penable;
    if (psel && !penable) begin
      st_nxt.pslverr = paddr != CTRL_OFF && paddr != STAT_OFF;
      st_nxt.prdata = paddr == CTRL_OFF ? 32'(st_r.ctrl) :
                      paddr == STAT_OFF ? status : 32'h0;
    end
    if (psel && penable && st_r.pready && pwrite && paddr == CTRL_OFF) begin
      st_nxt.ctrl = pwdata[CTRL_W-1:0];
    end
    // default pin directions for normal operation
    st_nxt.sclk_oe_n = 1'b1;
    st_nxt.sclk_out = 1'b0;
    st_nxt.rof_oe_n = fsp;
    st_nxt.chain_oe_n = 1'b1;
    st_nxt.chain_out = 1'b0;
    st_nxt.sync_oe_n = 1'b1;
    st_nxt.sync_out = 1'b0;
    st_nxt.dsel_oe_n = 1'b1;
    st_nxt.dsel_out = 1'b0;
    st_nxt.divcnt = 6'h00;
    st_nxt.mclk = 1'b0;
    if (tmode) begin
      st_nxt.dout = pd;
      st_nxt.chain_out = md[0];
      st_nxt.chain_oe_n = 1'b0;
      st_nxt.sync_out = md[1];
      st_nxt.sync_oe_n = 1'b0;
      st_nxt.dsel_out = fmt[0];
      st_nxt.dsel_oe_n = 1'b0;
      st_nxt.rof_out = fmt[1];
      st_nxt.rof_oe_n = 1'b0;
      st_nxt.sclk_out = fmt[2];
      st_nxt.sclk_oe_n = 1'b0;
      st_nxt.ph = PH_IDLE;
      st_nxt.hold_ok = 1'b0;
    end else if (modmode) begin
      // filter bypassed: clock pin turns output, ready pin driven low
      st_nxt.sclk_oe_n = 1'b0;
      st_nxt.sclk_out = st_r.mclk;
      st_nxt.rof_oe_n = 1'b0;
      st_nxt.rof_out = 1'b0;
      st_nxt.ph = PH_IDLE;
      st_nxt.hold_ok = 1'b0;
      st_nxt.mclk = st_r.mclk;
      if (st_r.divcnt + 6'h01 >= half) begin
        st_nxt.divcnt = 6'h00;
        st_nxt.mclk = !st_r.mclk;
        if (st_r.mclk) begin
          st_nxt.dout = mod_bits;
        end
      end else begin
        st_nxt.divcnt = st_r.divcnt + 6'h01;
      end
    end else if (!run) begin
      // every channel down: no data, no chain, ready stays high
      st_nxt.dout = '0;
      st_nxt.rof_out = !fsp;
      st_nxt.ph = PH_IDLE;
      st_nxt.hold_ok = 1'b0;
    end else begin
      if (conv_valid && fsp) begin
        st_nxt.hold = dyn ? pk : fixv;
        st_nxt.hnb = new_nb;
        st_nxt.hold_ok = 1'b1;
      end
      if (st_r.ph == PH_ARM) begin
        st_nxt.ph = PH_WAIT;
        st_nxt.rof_out = 1'b0;
      end
      if (xfer) begin
        st_nxt.nbits = nb;
        st_nxt.cnt = 8'h01;
        if (fsp && !conv_valid) begin
          st_nxt.hold_ok = 1'b0;
        end
        // spi: short high pulse, then ready low with msb valid
        st_nxt.ph = fsp ? PH_SHIFT : PH_ARM;
        st_nxt.rof_out = !fsp;
        if (disc) begin
          for (int i = 0; i < NCH; i++) begin
            st_nxt.dout[i] = src[FBITS-1-i*WBITS] && !pd[i];
          end
          st_nxt.sr = gshift(src);
        end else begin
          st_nxt.dout = {{(NCH-1){1'b0}}, nb != 8'h00 && src[FBITS-1]};
          st_nxt.sr = src << 1;
        end
      end else if (fall) begin
        if (st_r.cnt != CNT_SAT) begin
          st_nxt.cnt = st_r.cnt + 8'h01;
        end
        if (st_r.ph == PH_WAIT) begin
          st_nxt.ph = PH_SHIFT;
          st_nxt.rof_out = !fsp;
        end
        if (disc) begin
          // groups fill with zero, so pins fall to zero after 24 bits
          for (int i = 0; i < NCH; i++) begin
            st_nxt.dout[i] = st_r.sr[FBITS-1-i*WBITS] && !pd[i];
          end
          st_nxt.sr = gshift(st_r.sr);
        end else if (st_r.cnt < st_r.nbits) begin
          st_nxt.dout = {{(NCH-1){1'b0}}, st_r.sr[FBITS-1]};
          st_nxt.sr = st_r.sr << 1;
        end else begin
          st_nxt.dout = {{(NCH-1){1'b0}}, st_r.chain_s[1]};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RST;
      st_r.ph <= PH_IDLE;
      st_r.rof_out <= 1'b1;
      st_r.sclk_oe_n <= 1'b1;
      st_r.chain_oe_n <= 1'b1;
      st_r.sync_oe_n <= 1'b1;
      st_r.dsel_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign data_out = st_r.dout;
  assign sclk_out = st_r.sclk_out;
  assign sclk_oe_n = st_r.sclk_oe_n;
  assign ready_or_frame_pin_out = st_r.rof_out;
  assign ready_or_frame_pin_oe_n = st_r.rof_oe_n;
  assign chain_out = st_r.chain_out;
  assign chain_oe_n = st_r.chain_oe_n;
  assign sync_out = st_r.sync_out;
  assign sync_oe_n = st_r.sync_oe_n;
  assign clock_divider_select_out = st_r.dsel_out;
  assign clock_divider_select_oe_n = st_r.dsel_oe_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_chain;
    run && !disc && fall && !xfer && st_r.cnt >= st_r.nbits
      |=> st_r.dout[0] == $past(st_r.chain_s[1]);
  endproperty
  a_chain: assert property (p_chain)
    else $error("chain bit not passed through");

  property p_msb;
    run && !disc && fall && !xfer && st_r.cnt < st_r.nbits
      |=> st_r.dout[0] == $past(st_r.sr[FBITS-1]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("tdm bit order wrong");

  property p_alloff;
    alloff && !tmode && !modmode |=> st_r.dout == '0;
  endproperty
  a_alloff: assert property (p_alloff)
    else $error("outputs active with all channels down");

  property p_fixzero;
    xfer && !fsp && fmt == FMT_SPI_FIX && pd[0]
      |=> st_r.dout[0] == 1'b0 && st_r.nbits == 8'(FBITS);
  endproperty
  a_fixzero: assert property (p_fixzero)
    else $error("fixed slot not zero or not kept");

  property p_pack;
    xfer && !fsp && dyn
      |=> st_r.nbits == 8'(WBITS * $past($countones(~pd & chan_ready)));
  endproperty
  a_pack: assert property (p_pack)
    else $error("packed frame length wrong");

  property p_disc24;
    run && disc && fall && !xfer && st_r.cnt >= 8'h18 |=> st_r.dout == '0;
  endproperty
  a_disc24: assert property (p_disc24)
    else $error("discrete pin not zero after 24 bits");

  property p_discpd;
    run && disc && $stable(pd) |=> (st_r.dout & $past(pd)) == '0;
  endproperty
  a_discpd: assert property (p_discpd)
    else $error("powered-down discrete pin not zero");

  property p_frame_sync_input;
    fsp && fs_rise && st_r.hold_ok && run
      |=> st_r.ph == PH_SHIFT && st_r.cnt == 8'h01;
  endproperty
  a_frame_sync_input: assert property (p_frame_sync_input)
    else $error("frame sync did not present data");

  property p_modpins;
    modmode |=> !st_r.sclk_oe_n && !st_r.rof_oe_n && !st_r.rof_out;
  endproperty
  a_modpins: assert property (p_modpins)
    else $error("modulator mode pin directions wrong");

  property p_moddiv;
    modmode && md == MODE_HS && $stable(st_r.ctrl) && $rose(st_r.sclk_out)
      |-> st_r.sclk_out ##1 st_r.sclk_out ##1 !st_r.sclk_out;
  endproperty
  a_moddiv: assert property (p_moddiv)
    else $error("modulator clock not divide by 4");

  property p_fmt;
    fmt == FMT_MOD && !tmode |=> !st_r.sclk_oe_n;
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("format 110 did not enter modulator mode");

  property p_test;
    tmode |=> st_r.dout == $past(pd) && st_r.chain_out == $past(md[0])
      && st_r.sclk_out == $past(fmt[2]) && !st_r.chain_oe_n;
  endproperty
  a_test: assert property (p_test)
    else $error("pin test routing wrong");
endmodule
`default_nettype wire

// ### verilog/amf_pkg.sv
// Purpose: shared constants and types of the channel output formatter
// Assumes: one 24-bit word per channel, eight channels
// Notes: control and status sit on a small apb register file
`default_nettype none
package amf_pkg;
  localparam int NCH = 8;
  localparam int WBITS = 24;
  localparam int FBITS = NCH * WBITS;
  // register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  // control field positions
  localparam int PD_LSB = 0;
  localparam int MODE_LSB = 8;
  localparam int FMT_LSB = 10;
  localparam int TEST_LSB = 13;
  localparam int CTRL_W = 15;
  // all channels running, spi tdm dynamic, normal test
  localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;
  // output format codes
  localparam logic [2:0] FMT_SPI_DYN = 3'h0;
  localparam logic [2:0] FMT_SPI_FIX = 3'h1;
  localparam logic [2:0] FMT_SPI_DISC = 3'h2;
  localparam logic [2:0] FMT_FS_DYN = 3'h3;
  localparam logic [2:0] FMT_FS_FIX = 3'h4;
  localparam logic [2:0] FMT_FS_DISC = 3'h5;
  localparam logic [2:0] FMT_MOD = 3'h6;
  // speed modes
  localparam logic [1:0] MODE_HS = 2'h0;
  localparam logic [1:0] MODE_HR = 2'h1;
  localparam logic [1:0] MODE_LP = 2'h2;
  localparam logic [1:0] MODE_LS = 2'h3;
  // test select
  localparam logic [1:0] TEST_PINS = 2'h3;
  // modulator clock dividers, in master clock cycles
  localparam logic [5:0] DIV_4 = 6'h04;
  localparam logic [5:0] DIV_8 = 6'h08;
  localparam logic [5:0] DIV_40 = 6'h28;
  localparam logic [7:0] CNT_SAT = 8'hff;
  typedef enum logic [1:0] {PH_IDLE, PH_ARM, PH_WAIT, PH_SHIFT} amf_phase_e;
endpackage
`default_nettype wire

// ### test/amf_host_model.sv
// Purpose: host side model that clocks words out of the formatter
// Assumes: sclk stops low between frames, frame sync idles low
// Notes: captures all eight data pins at each sclk rise
`timescale 1ns/100ps
`default_nettype none
module amf_host_model (
  // clock
  input wire logic clk,
  // device pins
  input wire logic [7:0] dout,
  output logic sclk,
  output logic frame,
  output logic chain
);
  logic [7:0] cap [0:255];
  initial begin
    sclk = 1'b0;
    frame = 1'b0;
    chain = 1'b0;
  end
  // low phase of five clk lets the two-flop sampler update dout first
  // chain bits start at iteration c0, so the first one is sampled at the
  // fall that follows the last slot; the device does not buffer them
  task automatic shift(input int n, input int c0, input logic [7:0] pat);
    for (int i = 0; i < n; i++) begin
      cap[i] = dout;
      sclk <= 1'b1;
      chain <= (i >= c0 && i < c0 + 8) ? pat[7-(i-c0)] : 1'b0;
      repeat (3) @(posedge clk);
      sclk <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask
  task automatic frame_rise();
    frame <= 1'b1;
    repeat (4) @(posedge clk);
    frame <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### test/test_amf_formatter.sv
// Purpose: self-checking bench of the channel output formatter
// Assumes: apb slave answers within 20 cycles, host model on serial side
// Notes: sclk is stopped between frames in both protocols
`timescale 1ns/100ps
`default_nettype none
module test_amf_formatter;
  import amf_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, conv_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [FBITS-1:0] conv_word;
  logic [7:0] chan_ready, mod_bits, data_out;
  logic sclk_out, sclk_oe_n, rf_out, rf_oe_n, chain_out, chain_oe_n;
  logic sync_out, sync_oe_n, dsel_out, dsel_oe_n, tb_sync, tb_dsel;
  wire logic h_sclk, h_frame, h_chain;
  wire logic sclk_pin, rf_pin, chain_pin, sync_pin, dsel_pin;
  int num_errors, tests_run;
  assign sclk_pin = sclk_oe_n ? h_sclk : sclk_out;
  assign rf_pin = rf_oe_n ? h_frame : rf_out;
  assign chain_pin = chain_oe_n ? h_chain : chain_out;
  assign sync_pin = sync_oe_n ? tb_sync : sync_out;
  assign dsel_pin = dsel_oe_n ? tb_dsel : dsel_out;
  amf_formatter DUT (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_word(conv_word), .conv_valid(conv_valid),
    .chan_ready(chan_ready), .mod_bits(mod_bits), .data_out(data_out),
    .sclk_in(sclk_pin), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .ready_or_frame_pin_in(rf_pin), .ready_or_frame_pin_out(rf_out),
    .ready_or_frame_pin_oe_n(rf_oe_n), .chain_in(chain_pin),
    .chain_out(chain_out), .chain_oe_n(chain_oe_n), .sync_in(sync_pin),
    .sync_out(sync_out), .sync_oe_n(sync_oe_n),
    .clock_divider_select_in(dsel_pin),
    .clock_divider_select_out(dsel_out),
    .clock_divider_select_oe_n(dsel_oe_n));
  amf_host_model host (.clk(clk), .dout(data_out), .sclk(h_sclk),
    .frame(h_frame), .chain(h_chain));
  always #20 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never re-drives psel at once
    @(posedge clk);
  endtask
  task automatic set_ctrl(input logic [7:0] pd, input logic [1:0] m,
      input logic [2:0] f, input logic [1:0] t);
    logic [31:0] q;
    logic e;
    apb(1'b1, CTRL_OFF, 32'(pd) | (32'(m) << MODE_LSB) |
      (32'(f) << FMT_LSB) | (32'(t) << TEST_LSB), q, e);
  endtask
  // waits for a level on sclk_out, counting clk cycles into n
  task automatic wait_lvl(input logic v, inout int n);
    int g;
    g = 0;
    while (sclk_out !== v) begin
      @(posedge clk);
      n++;
      g++;
      if (g > 100) begin
        num_errors++;
        end_sim();
      end
    end
  endtask
  function automatic logic [23:0] word(input int c);
    return {4'h9, 4'(c), 16'h3c5a};
  endfunction
  initial begin
    logic [31:0] q;
    logic e;
    logic [7:0] ex [0:255];
    logic [7:0] pd, rdy, mb;
    logic [2:0] f;
    logic [23:0] w;
    logic disc, fix;
    int len, n, x, g;
    clk = 1'b0;
    arst_n = 1'b0;
    {psel, penable, pwrite, conv_valid, tb_sync, tb_dsel} = '0;
    paddr = '0;
    pwdata = '0;
    chan_ready = 8'hff;
    mod_bits = 8'h00;
    num_errors = 0;
    tests_run = 0;
    for (int c = 0; c < NCH; c++) conv_word[c*WBITS +: WBITS] = word(c);
    cyc(12);
    arst_n <= 1'b1;
    cyc(3);
    chk({rf_out, rf_oe_n, sclk_oe_n, chain_oe_n}, 4'hb);
    apb(1'b0, CTRL_OFF, 32'h0, q, e);
    chk(q, 32'(CTRL_RST));
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk(q, 32'h0);
    chk(e, 1'b1);
    tb_sync <= 1'b1;
    cyc(4);
    apb(1'b0, STAT_OFF, 32'h0, q, e);
    chk(q[19], 1'b1);
    // serial formats; case 6 has ch1 not ready, case 7 all down
    for (int k = 0; k < 8; k++) begin
      f = (k < 6) ? 3'(k) : (k == 6) ? FMT_SPI_DYN : FMT_SPI_FIX;
      pd = (k == 6) ? 8'h00 : (k == 7) ? 8'hff : 8'h05;
      rdy = (k == 6) ? 8'hfd : 8'hff;
      set_ctrl(pd, MODE_HS, f, 2'h0);
      chan_ready <= rdy;
      cyc(4);
      conv_valid <= 1'b1;
      cyc(1);
      conv_valid <= 1'b0;
      if (f == FMT_FS_DYN || f == FMT_FS_FIX || f == FMT_FS_DISC) begin
        cyc(2);
        host.frame_rise();
        cyc(6);
        chk(rf_oe_n, 1'b1);
      end else if (k < 7) begin
        g = 0;
        while (rf_out !== 1'b0 && g < 20) begin
          cyc(1);
          g++;
        end
        chk(g < 20, 1'b1);
        if (g >= 20) end_sim();
        cyc(1);
      end else cyc(4);
      for (int i = 0; i < 256; i++) ex[i] = 8'h00;
      disc = (f == FMT_SPI_DISC || f == FMT_FS_DISC);
      fix = (f == FMT_SPI_FIX || f == FMT_FS_FIX);
      len = 0;
      for (int c = 0; c < NCH; c++) begin
        w = pd[c] ? 24'h0 : word(c);
        for (int b = 0; b < WBITS; b++) begin
          if (disc) ex[b][c] = w[WBITS-1-b];
          else if (fix || (!pd[c] && rdy[c])) ex[len+b][0] = w[WBITS-1-b];
        end
        if (!disc && (fix || (!pd[c] && rdy[c]))) len += WBITS;
      end
      if (!disc && pd != 8'hff) begin
        for (int b = 0; b < 8; b++) ex[len+b][0] = 1'(8'hb4 >> (7 - b));
      end
      n = disc ? 30 : len + 8;
      host.shift(n, len - 1, 8'hb4);
      for (int i = 0; i < n; i++) begin
        if (disc) chk(host.cap[i], ex[i]);
        else chk(host.cap[i][0], ex[i][0]);
      end
    end
    for (int k = 0; k < 8; k++) begin
      mb = 8'h96 ^ 8'(k);
      tb_dsel <= k[0];
      mod_bits <= mb;
      set_ctrl(8'h00, 2'(k >> 1), FMT_MOD, 2'h0);
      cyc(100);
      x = 0;
      n = 0;
      wait_lvl(1'b0, x);
      wait_lvl(1'b1, x);
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      chk(n, (k < 5) ? 4 : (k == 7) ? 40 : 8);
      chk({sclk_oe_n, rf_out, data_out}, {2'b00, mb});
    end
    for (int k = 0; k < 2; k++) begin
      pd = k ? 8'hc3 : 8'h3c;
      f = k ? 3'b010 : 3'b101;
      set_ctrl(pd, k ? 2'b10 : 2'b01, f, TEST_PINS);
      cyc(6);
      chk({data_out, chain_out, sync_out, dsel_out, rf_out, sclk_out},
        {pd, ~1'(k), 1'(k), f[0], f[1], f[2]});
      chk({chain_oe_n, sync_oe_n, dsel_oe_n, rf_oe_n, sclk_oe_n}, 0);
    end
    set_ctrl(8'h00, MODE_HS, FMT_SPI_DYN, 2'h0);
    cyc(6);
    chk({chain_oe_n, sync_oe_n, dsel_oe_n}, 3'h7);
    end_sim();
  end
endmodule
`default_nettype wire
